// ---- cpu_ctrl_map.vh ----
/*
 * Constants for the CPU decode and execution control block: first-byte opcodes,
 * flag positions, state counts and register port offsets.
 * Assumes inclusion by the control block and its port checker; definitions only.
 */
`ifndef CPU_CTRL_MAP_VH
`define CPU_CTRL_MAP_VH

// Condition code bit positions
`define CCR_I 7
`define CCR_H 5
`define CCR_N 3
`define CCR_Z 2
`define CCR_V 1
`define CCR_C 0
`define CCR_RESET 8'h80

// First-byte opcodes of the control group
`define OP_NOP   8'h00
`define OP_SLEEP 8'h01
`define OP_STC   8'h02
`define OP_LDCR  8'h03
`define OP_ORC   8'h04
`define OP_XOR_COND_REG  8'h05
`define OP_AND_COND_REG  8'h06
`define OP_LDCI  8'h07
`define OP_ADD_WITH_CARRY  8'h0E
`define OP_DAA   8'h0F
`define OP_SUB_WITH_BORROW  8'h1E
`define OP_DAS   8'h1F
`define OP_BRA   8'h40
`define OP_BRN   8'h41
`define OP_BCC   8'h44
`define OP_BCS   8'h45
`define OP_UNSIGNED_DIVIDE 8'h51
`define OP_RTS   8'h54
`define OP_RTE   8'h56
`define OP_JSRI  8'h5F
`define OP_MOVX  8'h6A
`define OP_BMOV  8'h7B
`define OP_ADDW  8'h09
`define OP_SUBW  8'h19

// Low bits of byte 2 that separate the peripheral-synchronised moves
`define PSYNC_LOW_MASK 7'h70
`define PSYNC_LOW_CODE 7'h40
`define PSYNC_TO_BIT   3

// State counts with code and operands in on-chip memory
`define ST_SHORT 2
`define ST_CALL  8
`define ST_RET   8
`define ST_ERET  10
`define ST_BMOVB 8
`define ST_BMOVK 4

// Register port offsets
`define ADR_CTRL   4'h0
`define ADR_STATUS 4'h1
`define ADR_CCR    4'h2
`define ADR_SP     4'h3
`define ADR_PC     4'h4
`define ADR_OPCLS  4'h5

`endif

// ---- cpu_control_and_opcode_decode.v ----
/*
 * Decode and execution control of an 8/16-bit CPU: first-byte opcode map,
 * call/return/sleep/condition-code group, flag rules and state counting.
 * Assumes program memory presents a word on INSTR with INSTR_VALID, and a
 * data port returns stack words in the same cycle (on-chip memory timing).
 */
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "cpu_ctrl_map.vh"

// Contract
// - Indirect call: push PC, load from table, 8
// - Return: pop PC, SP+2, 8 states
// - Exception return pops CONDITION_CODE_REG then PC, 10
// - Sleep enters power-down, flags kept, 2 states
// - State counts assume on-chip code and operands
// - Word half-carry from bit 11
// - Extended ops keep Z on zero result
// - Decimal adjust sets carry, else keeps
// - Block move takes 4n+8 states
// - Divide N flag follows divisor sign
// - Divide Z flag marks zero divisor
// - Decode from first byte, two nibbles
// - Bit 7 splits shared first bytes
// - Low byte-2 bits separate synchronised moves
// - Push and pop decode as moves
// - Branch aliases decode as their twins
// - High nibble 8-F selects immediate ALU ops
module cpu_control_and_opcode_decode (
	input  wire        CLK_SYS,
	input  wire        RST_N,
	input  wire [15:0] INSTR,
	input  wire        INSTR_VALID,
	output wire        INSTR_READY,
	input  wire [15:0] MEM_RDATA,
	output reg  [15:0] MEM_ADDR,
	output reg  [15:0] MEM_WDATA,
	output reg         MEM_WE,
	output reg         MEM_RE,
	input  wire [7:0]  OPND_B,
	input  wire [15:0] OPND_A,
	input  wire [15:0] OPND_W,
	input  wire        WAKE,
	output reg         SLEEPING,
	output reg  [4:0]  OP_CLASS,
	input  wire [3:0]  REG_ADDR,
	input  wire [15:0] REG_WDATA,
	input  wire        REG_WR,
	input  wire        REG_RD,
	output reg  [15:0] REG_RDATA
);

	// Operation classes reported on OP_CLASS
	localparam [4:0] C_NOP = 5'h00, C_SLEEP = 5'h01, C_CCR = 5'h02, C_CALL = 5'h03,
		C_RET = 5'h04, C_ERET = 5'h05, C_ADD_WITH_CARRY = 5'h06, C_SUB_WITH_BORROW = 5'h07,
		C_DADJ = 5'h08, C_DIV = 5'h09, C_BMOV = 5'h0A, C_MOV = 5'h0B,
		C_PSYNC = 5'h0C, C_BRA = 5'h0D, C_BRN = 5'h0E, C_BCC = 5'h0F,
		C_BCS = 5'h10, C_ALU = 5'h11, C_WORD = 5'h12, C_OTHER = 5'h13;

	// One-hot sequencer states
	localparam [4:0] S_IDLE = 5'b00001, S_EXEC = 5'b00010, S_MEM1 = 5'b00100,
		S_MEM2 = 5'b01000, S_SLEEP = 5'b10000;

	reg [4:0]  state_reg, state_next;
	reg [7:0]  ccr_reg, ccr_next;
	reg [15:0] sp_reg, sp_next;
	reg [15:0] pc_reg, pc_next;
	reg [15:0] ir_reg;
	reg [10:0] cnt_reg, cnt_next;
	reg        ctrl_sleep_en_reg;
	reg        wake_s1_reg, wake_s2_reg;
	reg [4:0]  cls;
	reg [12:0] lowsum;
	reg [16:0] wsum;
	reg        dcarry;

	// First-byte decode; used for acceptance and for execution
	function [4:0] decode;
		input [15:0] w;
		begin
			case (w[15:8])
			`OP_NOP:   decode = C_NOP;
			`OP_SLEEP: decode = C_SLEEP;
			`OP_STC, `OP_LDCR, `OP_ORC, `OP_XOR_COND_REG, `OP_AND_COND_REG, `OP_LDCI: decode = C_CCR;
			`OP_ADD_WITH_CARRY:  decode = C_ADD_WITH_CARRY;
			`OP_SUB_WITH_BORROW:  decode = C_SUB_WITH_BORROW;
			`OP_DAA, `OP_DAS: decode = C_DADJ;
			`OP_BRA:   decode = C_BRA;
			`OP_BRN:   decode = C_BRN;
			`OP_BCC:   decode = C_BCC;
			`OP_BCS:   decode = C_BCS;
			`OP_UNSIGNED_DIVIDE: decode = C_DIV;
			`OP_RTS:   decode = C_RET;
			`OP_RTE:   decode = C_ERET;
			`OP_JSRI:  decode = C_CALL;
			`OP_ADDW, `OP_SUBW: decode = C_WORD;
			// Bit 7 picks block move over move in the shared byte
			`OP_BMOV:  decode = w[7] ? C_BMOV : C_MOV;
			`OP_MOVX: begin
				// Push/pop need nothing: they are plain moves
				if ((w[6:0] & `PSYNC_LOW_MASK) == `PSYNC_LOW_CODE)
					decode = C_PSYNC;
				else
					decode = C_MOV;
			end
			default: begin
				if (w[15])
					decode = C_ALU;
				else
					decode = C_OTHER;
			end
			endcase
		end
	endfunction

	// Ready only when idle; sleep and multi-state work hold the fetch
	assign INSTR_READY = state_reg[0];

	// Two-flop synchroniser for the external wake level
	always @(posedge CLK_SYS) begin
		if (!RST_N) begin
			wake_s1_reg <= 1'b0;
			wake_s2_reg <= 1'b0;
		end else begin
			wake_s1_reg <= WAKE;
			wake_s2_reg <= wake_s1_reg;
		end
	end

	// Next-state, flag and sequencing logic
	always @* begin
		state_next = state_reg;
		ccr_next   = ccr_reg;
		sp_next    = sp_reg;
		pc_next    = pc_reg;
		cnt_next   = cnt_reg;
		cls        = decode(ir_reg);
		lowsum     = 13'h0000;
		wsum       = 17'h00000;
		dcarry     = 1'b0;
		case (state_reg)
		S_IDLE: begin
			if (INSTR_VALID)
				state_next = S_EXEC;
		end
		S_EXEC: begin
			// Counts below hold for on-chip fetch and data only
			cnt_next = 11'd`ST_SHORT - 11'd1;
			pc_next = pc_reg + 16'h0002;
			state_next = S_MEM2;
			case (cls)
			C_SLEEP: begin
				if (ctrl_sleep_en_reg)
					state_next = S_SLEEP;
			end
			C_CCR: begin
				case (ir_reg[15:8])
				`OP_LDCI: ccr_next = ir_reg[7:0];
				`OP_LDCR: ccr_next = OPND_B;
				`OP_AND_COND_REG: ccr_next = ccr_reg & ir_reg[7:0];
				`OP_ORC:  ccr_next = ccr_reg | ir_reg[7:0];
				`OP_XOR_COND_REG: ccr_next = ccr_reg ^ ir_reg[7:0];
				default:  ccr_next = ccr_reg;
				endcase
			end
			C_CALL: begin
				sp_next = sp_reg - 16'h0002;
				cnt_next = 11'd`ST_CALL - 11'd1;
				state_next = S_MEM1;
			end
			C_RET: begin
				cnt_next = 11'd`ST_RET - 11'd1;
				state_next = S_MEM1;
			end
			C_ERET: begin
				cnt_next = 11'd`ST_ERET - 11'd1;
				state_next = S_MEM1;
			end
			C_ADD_WITH_CARRY, C_SUB_WITH_BORROW: begin
				wsum = (cls == C_ADD_WITH_CARRY) ?
					{9'h000, OPND_A[7:0]} + {9'h000, OPND_B} + {16'h0000, ccr_reg[`CCR_C]} :
					{9'h000, OPND_A[7:0]} - {9'h000, OPND_B} - {16'h0000, ccr_reg[`CCR_C]};
				ccr_next[`CCR_C] = wsum[8];
				ccr_next[`CCR_N] = wsum[7];
				if (wsum[7:0] != 8'h00)
					ccr_next[`CCR_Z] = 1'b0;
			end
			C_WORD: begin
				lowsum = (ir_reg[12]) ? {1'b0, OPND_A[11:0]} - {1'b0, OPND_W[11:0]} :
					{1'b0, OPND_A[11:0]} + {1'b0, OPND_W[11:0]};
				// Bit 12 is the carry or borrow out of bit 11
				ccr_next[`CCR_H] = lowsum[12];
			end
			C_DADJ: begin
				dcarry = (OPND_A[7:0] > 8'h99) | ccr_reg[`CCR_C];
				if (dcarry)
					ccr_next[`CCR_C] = 1'b1;
			end
			C_DIV: begin
				ccr_next[`CCR_N] = OPND_B[7];
				ccr_next[`CCR_Z] = (OPND_B == 8'h00);
			end
			C_BMOV: begin
				cnt_next = ({3'b000, OPND_B} << 2) + 11'd`ST_BMOVB - 11'd1;
			end
			default: ;
			endcase
		end
		S_MEM1: begin
			cnt_next = cnt_reg - 11'd1;
			case (cls)
			C_RET: begin
				pc_next = MEM_RDATA;
				sp_next = sp_reg + 16'h0002;
			end
			C_ERET: begin
				ccr_next = MEM_RDATA[7:0];
				sp_next = sp_reg + 16'h0002;
			end
			default: ;
			endcase
			state_next = S_MEM2;
		end
		S_MEM2: begin
			if (cnt_reg > 11'd1) begin
				cnt_next = cnt_reg - 11'd1;
			end else begin
				cnt_next = 11'd0;
				state_next = S_IDLE;
			end
			if (cls == C_ERET && cnt_reg == 11'd`ST_ERET - 11'd2) begin
				pc_next = MEM_RDATA;
				sp_next = sp_reg + 16'h0002;
			end
			// Vector word is on the bus only in this slot
			if (cls == C_CALL && cnt_reg == 11'd`ST_CALL - 11'd2)
				pc_next = MEM_RDATA;
		end
		S_SLEEP: begin
			if (wake_s2_reg)
				state_next = S_IDLE;
		end
		default: state_next = S_IDLE;
		endcase
	end

	// Memory strobes for stack and vector traffic
	always @* begin
		MEM_ADDR  = 16'h0000;
		MEM_WDATA = 16'h0000;
		MEM_WE    = 1'b0;
		MEM_RE    = 1'b0;
		if (state_reg == S_MEM1) begin
			case (cls)
			C_CALL: begin
				MEM_WE    = 1'b1;
				MEM_ADDR  = sp_reg;
				MEM_WDATA = pc_reg;
			end
			C_RET, C_ERET: begin
				MEM_RE   = 1'b1;
				MEM_ADDR = sp_reg;
			end
			default: ;
			endcase
		end else if (state_reg == S_MEM2 && cls == C_CALL && cnt_reg == 11'd`ST_CALL - 11'd2) begin
			MEM_RE   = 1'b1;
			MEM_ADDR = {8'h00, ir_reg[7:0]};
		end else if (state_reg == S_MEM2 && cls == C_ERET &&
			cnt_reg == 11'd`ST_ERET - 11'd2) begin
			MEM_RE   = 1'b1;
			MEM_ADDR = sp_reg;
		end
	end

	// Sequencer registers
	always @(posedge CLK_SYS) begin
		if (!RST_N) begin
			state_reg <= S_IDLE;
			ccr_reg   <= `CCR_RESET;
			sp_reg    <= 16'h0000;
			pc_reg    <= 16'h0000;
			cnt_reg   <= 11'd0;
			ir_reg    <= 16'h0000;
			SLEEPING  <= 1'b0;
			OP_CLASS  <= 5'h00;
		end else begin
			state_reg <= state_next;
			ccr_reg   <= ccr_next;
			sp_reg    <= sp_next;
			pc_reg    <= pc_next;
			cnt_reg   <= cnt_next;
			SLEEPING  <= (state_next == S_SLEEP);
			if (state_reg == S_IDLE && INSTR_VALID) begin
				ir_reg   <= INSTR;
				OP_CLASS <= decode(INSTR);
			end
			// Software writes lose to the sequencer only while busy
			if (REG_WR && state_reg == S_IDLE) begin
				case (REG_ADDR)
				`ADR_CCR: ccr_reg <= REG_WDATA[7:0];
				`ADR_SP:  sp_reg  <= REG_WDATA;
				`ADR_PC:  pc_reg  <= REG_WDATA;
				default: ;
				endcase
			end
		end
	end

	// Control register and read port
	always @(posedge CLK_SYS) begin
		if (!RST_N) begin
			ctrl_sleep_en_reg <= 1'b1;
			REG_RDATA         <= 16'h0000;
		end else begin
			if (REG_WR && REG_ADDR == `ADR_CTRL)
				ctrl_sleep_en_reg <= REG_WDATA[0];
			if (REG_RD) begin
				case (REG_ADDR)
				`ADR_CTRL:   REG_RDATA <= {15'h0000, ctrl_sleep_en_reg};
				`ADR_STATUS: REG_RDATA <= {11'h000, state_reg};
				`ADR_CCR:    REG_RDATA <= {8'h00, ccr_reg};
				`ADR_SP:     REG_RDATA <= sp_reg;
				`ADR_PC:     REG_RDATA <= pc_reg;
				`ADR_OPCLS:  REG_RDATA <= {11'h000, OP_CLASS};
				default:     REG_RDATA <= 16'h0000;
				endcase
			end else begin
				REG_RDATA <= 16'h0000;
			end
		end
	end

endmodule

// ---- stack_mem_model.sv ----
/* Data memory model for stack and vector words.
   Assumes one-cycle strobes from the block and same-cycle read return. */
`timescale 1ns/1ps
module stack_mem_model (
	input  wire        clk,
	input  wire [15:0] addr,
	input  wire [15:0] wdata,
	input  wire        we,
	input  wire        re,
	output wire [15:0] rdata
);
	reg     [15:0] mem [0:255];
	reg     [15:0] last_reg;
	integer        k;
	// Distinct word per address so a wrong address shows
	initial begin
		last_reg = 16'h0000;
		for (k = 0; k < 256; k = k + 1)
			mem[k] = {k[7:0], ~k[7:0]};
	end
	// Unselected bus shows the inverse of the last word, never a stale match
	assign rdata = re ? mem[addr[7:0]] : ~last_reg;
	// Writes land on the edge
	always @(posedge clk) begin
		if (we)
			mem[addr[7:0]] <= wdata;
		if (re)
			last_reg <= mem[addr[7:0]];
	end
endmodule

// ---- cpu_ctrl_monitor.sv ----
/* Port checker for the decode and control block.
   Assumes bind to the block; clock CLK_SYS, sync reset RST_N. */
`timescale 1ns/1ps
`include "cpu_ctrl_map.vh"
module cpu_ctrl_monitor (
	input wire        CLK_SYS,
	input wire        RST_N,
	input wire [15:0] INSTR,
	input wire        INSTR_VALID,
	input wire        INSTR_READY,
	input wire [15:0] MEM_ADDR,
	input wire        MEM_RE,
	input wire        MEM_WE,
	input wire [7:0]  OPND_B,
	input wire        SLEEPING,
	input wire [4:0]  OP_CLASS,
	input wire        REG_RD,
	input wire [15:0] REG_RDATA
);
	wire        acc = INSTR_VALID && INSTR_READY;
	wire [7:0]  op  = INSTR[15:8];
	reg  [11:0] busy_reg;
	// Busy cycles since accept; long counts exceed any repetition
	always @(posedge CLK_SYS)
		busy_reg <= (!RST_N || acc) ? 12'h000 : busy_reg + {11'h000, !INSTR_READY};
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);
	sequence push_vec;
		MEM_WE ##1 (MEM_RE && MEM_ADDR == {8'h00, $past(INSTR[7:0], 3)});
	endsequence
	sequence two_pops;
		MEM_RE ##1 MEM_RE;
	endsequence
	call_steps_a: assert property (acc && op == `OP_JSRI
		|-> ##2 push_vec ##6 INSTR_READY)
		else $error("call sequence wrong");
	ret_steps_a: assert property (acc && op == `OP_RTS
		|-> ##2 MEM_RE ##7 INSTR_READY)
		else $error("return sequence wrong");
	eret_steps_a: assert property (acc && op == `OP_RTE
		|-> ##2 two_pops ##8 INSTR_READY)
		else $error("exception return sequence wrong");
	nop_time_a: assert property (acc && op == `OP_NOP
		|=> !INSTR_READY[*2] ##1 INSTR_READY)
		else $error("no-operation timing wrong");
	ccr_time_a: assert property ($rose(INSTR_READY) && OP_CLASS == 5'h02
		|-> busy_reg == 12'h002)
		else $error("condition register op timing wrong");
	bmove_time_a: assert property ($rose(INSTR_READY) && OP_CLASS == 5'h0A
		|-> busy_reg == {2'h0, OPND_B, 2'h0} + 12'h008)
		else $error("block move timing wrong");
	sleep_enter_a: assert property (acc && op == `OP_SLEEP
		|-> ##[1:3] SLEEPING)
		else $error("sleep not entered");
	sleep_hold_a: assert property (SLEEPING |-> !INSTR_READY)
		else $error("ready while sleeping");
	imm_alu_a: assert property (acc && INSTR[15] |=> OP_CLASS == 5'h11)
		else $error("immediate group decode wrong");
	psync_sel_a: assert property (acc && op == `OP_MOVX
		&& (INSTR[6:0] & `PSYNC_LOW_MASK) == `PSYNC_LOW_CODE |=> OP_CLASS == 5'h0C)
		else $error("synchronised move decode wrong");
	rdata_idle_a: assert property (!$past(REG_RD) |-> REG_RDATA == 16'h0000)
		else $error("read data outside read slot");
endmodule

// ---- cpu_control_and_opcode_decode_tb.sv ----
/* Self-checking bench for the decode and control block.
   Assumes the data memory model answers stack and vector accesses. */
`timescale 1ns/1ps
module cpu_control_and_opcode_decode_tb;
	reg         CLK_SYS, RST_N, INSTR_VALID, WAKE, REG_WR, REG_RD;
	reg  [15:0] INSTR, OPND_A, OPND_W, REG_WDATA;
	reg  [7:0]  OPND_B;
	reg  [3:0]  REG_ADDR;
	wire [15:0] MEM_RDATA, MEM_ADDR, MEM_WDATA, REG_RDATA;
	wire        MEM_WE, MEM_RE, INSTR_READY, SLEEPING;
	wire [4:0]  OP_CLASS;
	integer     failures, compares, cycles;
	cpu_control_and_opcode_decode i_cpu_control_and_opcode_decode (
		.CLK_SYS(CLK_SYS), .RST_N(RST_N), .INSTR(INSTR), .INSTR_VALID(INSTR_VALID),
		.INSTR_READY(INSTR_READY), .MEM_RDATA(MEM_RDATA), .MEM_ADDR(MEM_ADDR),
		.MEM_WDATA(MEM_WDATA), .MEM_WE(MEM_WE), .MEM_RE(MEM_RE), .OPND_B(OPND_B),
		.OPND_A(OPND_A), .OPND_W(OPND_W), .WAKE(WAKE), .SLEEPING(SLEEPING),
		.OP_CLASS(OP_CLASS), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
		.REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA));
	stack_mem_model i_stack_mem_model (.clk(CLK_SYS), .addr(MEM_ADDR), .wdata(MEM_WDATA),
		.we(MEM_WE), .re(MEM_RE), .rdata(MEM_RDATA));
	task check(input [15:0] seen, input [15:0] exp);
		begin
			compares = compares + 1;
			if (seen !== exp) begin
				failures = failures + 1;
				$display("ERROR %0t seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task wr(input [3:0] a, input [15:0] d);
		begin
			@(posedge CLK_SYS);
			REG_ADDR <= a;
			REG_WDATA <= d;
			REG_WR <= 1'b1;
			@(posedge CLK_SYS);
			REG_WR <= 1'b0;
		end
	endtask
	task rd(input [3:0] a, input [15:0] m, input [15:0] e);
		begin
			@(posedge CLK_SYS);
			REG_ADDR <= a;
			REG_RD <= 1'b1;
			@(posedge CLK_SYS);
			REG_RD <= 1'b0;
			@(negedge CLK_SYS);
			check(REG_RDATA & m, e);
		end
	endtask
	// Offer one word and hold it until the accepting edge
	task issue(input [15:0] i, input [15:0] a, input [7:0] b);
		begin
			@(posedge CLK_SYS);
			INSTR <= i;
			OPND_A <= a;
			OPND_W <= a;
			OPND_B <= b;
			INSTR_VALID <= 1'b1;
			@(negedge CLK_SYS);
			while (INSTR_READY !== 1'b1)
				@(negedge CLK_SYS);
			@(posedge CLK_SYS);
			INSTR_VALID <= 1'b0;
		end
	endtask
	task settle;
		begin
			@(negedge CLK_SYS);
			while (INSTR_READY !== 1'b1)
				@(negedge CLK_SYS);
		end
	endtask
	task go(input [15:0] i, input [15:0] a, input [7:0] b);
		begin
			issue(i, a, b);
			settle;
		end
	endtask
	// Preset flags, run one word, compare masked flags
	task fl(input [7:0] c, input [15:0] i, input [15:0] a, input [7:0] b,
		input [7:0] m, input [7:0] e);
		begin
			wr(4'h2, {8'h00, c});
			go(i, a, b);
			rd(4'h2, {8'h00, m}, {8'h00, e});
		end
	endtask
	task cl(input [15:0] i, input [4:0] e);
		begin
			go(i, 16'h0000, 8'h00);
			check({11'h000, OP_CLASS}, {11'h000, e});
		end
	endtask
	task tally_and_finish;
		begin
			$display("compares %0d failures %0d", compares, failures);
			if (failures == 0 && compares > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask
	initial begin
		CLK_SYS = 1'b0;
		forever #2.5 CLK_SYS = ~CLK_SYS;
	end
	// Hang guard; the whole sequence needs well under this
	always @(posedge CLK_SYS) begin
		cycles = cycles + 1;
		if (cycles == 4000) begin
			failures = failures + 1;
			tally_and_finish;
		end
	end
	initial begin
		{RST_N, INSTR_VALID, WAKE, REG_WR, REG_RD} = 5'h00;
		{INSTR, OPND_A, OPND_W, REG_WDATA, OPND_B, REG_ADDR} = 76'h0;
		failures = 0;
		compares = 0;
		cycles = 0;
		repeat (6) @(posedge CLK_SYS);
		RST_N <= 1'b1;
		rd(4'h2, 16'h00FF, 16'h0080);
		rd(4'h0, 16'h0001, 16'h0001);
		rd(4'h3, 16'hFFFF, 16'h0000);
		rd(4'hF, 16'hFFFF, 16'h0000);
		wr(4'h3, 16'h0080);
		go(16'h5F20, 16'h0000, 8'h00);
		rd(4'h4, 16'hFFFF, 16'h20DF);
		rd(4'h3, 16'hFFFF, 16'h007E);
		fl(8'h0F, 16'h5400, 16'h0000, 8'h00, 8'hFF, 8'h0F);
		rd(4'h3, 16'hFFFF, 16'h0080);
		rd(4'h4, 16'hFFFF, 16'h0002);
		go(16'h5600, 16'h0000, 8'h00);
		rd(4'h3, 16'hFFFF, 16'h0084);
		rd(4'h2, 16'h00FF, 16'h007F);
		rd(4'h4, 16'hFFFF, 16'h827D);
		fl(8'h00, 16'h0900, 16'h0800, 8'h00, 8'h20, 8'h20);
		fl(8'h20, 16'h0900, 16'h0001, 8'h00, 8'h20, 8'h00);
		fl(8'h04, 16'h0E00, 16'h0000, 8'h00, 8'h04, 8'h04);
		fl(8'h00, 16'h0E00, 16'h0000, 8'h00, 8'h04, 8'h00);
		fl(8'h04, 16'h0E00, 16'h0001, 8'h00, 8'h04, 8'h00);
		fl(8'h00, 16'h0F00, 16'h00A0, 8'h00, 8'h01, 8'h01);
		fl(8'h01, 16'h0F00, 16'h0012, 8'h00, 8'h01, 8'h01);
		fl(8'h00, 16'h0F00, 16'h0012, 8'h00, 8'h01, 8'h00);
		fl(8'h00, 16'h5100, 16'h0010, 8'h00, 8'h0C, 8'h04);
		fl(8'h00, 16'h5100, 16'h0010, 8'h80, 8'h0C, 8'h08);
		fl(8'h00, 16'h075A, 16'h0000, 8'h00, 8'hFF, 8'h5A);
		fl(8'hFF, 16'h060F, 16'h0000, 8'h00, 8'hFF, 8'h0F);
		fl(8'h00, 16'h0430, 16'h0000, 8'h00, 8'hFF, 8'h30);
		fl(8'h0F, 16'h05FF, 16'h0000, 8'h00, 8'hFF, 8'hF0);
		fl(8'h00, 16'h0300, 16'h0000, 8'hC4, 8'hFF, 8'hC4);
		fl(8'h33, 16'h0200, 16'h0000, 8'h00, 8'hFF, 8'h33);
		wr(4'h4, 16'h1000);
		fl(8'h2B, 16'h0000, 16'h0000, 8'h00, 8'hFF, 8'h2B);
		rd(4'h4, 16'hFFFF, 16'h1002);
		wr(4'h2, 16'h0021);
		issue(16'h0100, 16'h0000, 8'h00);
		repeat (4) @(negedge CLK_SYS);
		check({15'h0000, SLEEPING}, 16'h0001);
		@(posedge CLK_SYS);
		WAKE <= 1'b1;
		settle;
		@(posedge CLK_SYS);
		WAKE <= 1'b0;
		rd(4'h2, 16'h00FF, 16'h0021);
		cl(16'h0000, 5'h00);
		cl(16'h0E00, 5'h06);
		cl(16'h1E00, 5'h07);
		cl(16'h1F00, 5'h08);
		cl(16'h0900, 5'h12);
		cl(16'h4000, 5'h0D);
		cl(16'h4100, 5'h0E);
		cl(16'h4400, 5'h0F);
		cl(16'h4500, 5'h10);
		cl(16'h8000, 5'h11);
		cl(16'hF0FF, 5'h11);
		cl(16'h6A00, 5'h0B);
		cl(16'h6A48, 5'h0C);
		// Bit 7 of the word picks block move over plain move
		cl(16'h7B00, 5'h0B);
		go(16'h7B80, 16'h0000, 8'h03);
		cl(16'h7B80, 5'h0A);
		tally_and_finish;
	end
endmodule
bind cpu_control_and_opcode_decode cpu_ctrl_monitor i_cpu_ctrl_monitor (
	.CLK_SYS(CLK_SYS), .RST_N(RST_N), .INSTR(INSTR), .INSTR_VALID(INSTR_VALID),
	.INSTR_READY(INSTR_READY), .MEM_ADDR(MEM_ADDR), .MEM_RE(MEM_RE), .MEM_WE(MEM_WE),
	.OPND_B(OPND_B), .SLEEPING(SLEEPING), .OP_CLASS(OP_CLASS), .REG_RD(REG_RD),
	.REG_RDATA(REG_RDATA));
